// File: hw/temp_status_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package; the bank module uses its macros without an include of its own
`ifndef TEMP_STATUS_REGS_SVH
`define TEMP_STATUS_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_PRIMARY_STATUS 8'h02
`define OFS_REMOTE_OT_LIMIT 8'h07
`define OFS_REMOTE_OT_ALIAS 8'h0D
`define OFS_REMOTE_CRIT_LIMIT 8'h19
`define OFS_LOCAL_LIMIT 8'h20
`define OFS_COMMON_HYST 8'h21
`define OFS_SECONDARY_STATUS 8'h33
`define OFS_MAKER_ID 8'hFE
`define OFS_SILICON_REV 8'hFF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PST_BUSY_BIT 7
`define PST_REMOTE_OT_BIT 4
`define PST_DIODE_FAULT_BIT 2
`define PST_REMOTE_CRIT_BIT 1
`define PST_LOCAL_BIT 0
`define SST_NOT_READY_BIT 7
`define SST_DETECT_BIT 6
`define HYST_MSB 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_REMOTE_OT_LIMIT 8'h55
`define RST_REMOTE_CRIT_LIMIT 8'h6E
`define RST_LOCAL_LIMIT 8'h55
`define RST_COMMON_HYST 5'h0A

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define POWERUP_TIME_MS 30
`define POWERUP_CYCLES \
   ((`POWERUP_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// File: hw/temp_status_pkg.sv
// types shared by the sensor status and limit bank
// assumes the constants header sits beside it
package temp_status_pkg;
`include "temp_status_regs.svh"

   // power-up sequencing of the readiness flag
   typedef enum logic [0:0]
   {
      PWR_WAIT = 1'b0,
      PWR_READY = 1'b1
   } pwr_state_t;

   // one temperature reading, whole degrees unsigned
   typedef logic [7:0] temp_deg_t;
endpackage

// File: hw/meas_capture.sv
// measurement-side capture of finished conversion results
// assumes it runs on the measurement engine clock; the bank side
// samples the held words only after the toggle has been synchronised
`timescale 1ns/1ps
module meas_capture
   import temp_status_pkg::*;
(
   // clock and reset
   input wire logic i_meas_clk,
   input wire logic i_rst,
   // results from the conversion engine
   input wire logic i_sample_stb,
   input wire temp_deg_t i_remote_temp,
   input wire temp_deg_t i_local_temp,
   // held words and event toggle toward the bank
   output temp_deg_t o_remote_hold,
   output temp_deg_t o_local_hold,
   output logic o_toggle
);

   // ----------------------------------------------------------------
   // holding registers
   // ----------------------------------------------------------------
   temp_deg_t remote_hold_ff; // last remote result
   temp_deg_t local_hold_ff; // last local result
   logic toggle_ff; // flips once per result

   // capture both words on each finished conversion
   always_ff @(posedge i_meas_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         remote_hold_ff <= 8'h00;
         local_hold_ff <= 8'h00;
      end
      else if (i_sample_stb)
      begin
         remote_hold_ff <= i_remote_temp;
         local_hold_ff <= i_local_temp;
      end
   end

   // event toggle, crosses as a level
   always_ff @(posedge i_meas_clk or posedge i_rst)
   begin
      if (i_rst)
         toggle_ff <= 1'b0;
      else if (i_sample_stb)
         toggle_ff <= ~toggle_ff;
   end

   assign o_remote_hold = remote_hold_ff;
   assign o_local_hold = local_hold_ff;
   assign o_toggle = toggle_ff;
endmodule

// File: hw/temp_status_bank.sv
// status, limit, hysteresis and identification bank of a remote-diode
// temperature sensor; the serial protocol engine in front of it offers
// a byte-wide register port on i_clk, the conversion engine sits on
// its own clock and hands results over through meas_capture
`timescale 1ns/1ps
module temp_status_bank
   import temp_status_pkg::*;
#(
   // power-up wait in i_clk cycles, shorten in simulation
   parameter int unsigned POWERUP_CYCLES = `POWERUP_CYCLES,
   // maker code, value arbitrary
   parameter logic [7:0] MAKER_ID = 8'h5A,
   // silicon revision code, value arbitrary
   parameter logic [7:0] SILICON_REV = 8'h03
)
(
   // system clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // register port from the serial protocol engine
   input wire logic [7:0] i_addr,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_data,
   input wire logic i_rd_en,
   output logic [7:0] o_rd_data,
   output logic o_rd_valid,
   // measurement domain
   input wire logic i_meas_clk,
   input wire logic i_sample_stb,
   input wire logic [7:0] i_remote_temp,
   input wire logic [7:0] i_local_temp,
   input wire logic i_busy,
   input wire logic i_diode_fault,
   input wire logic i_beta_comp_transistor_detect,
   input wire logic i_beta_comp_enable,
   // alarm outputs
   output logic o_critical_alarm_output,
   output logic o_overtemp_shutdown_output
);

   // ----------------------------------------------------------------
   // measurement handover
   // ----------------------------------------------------------------
   temp_deg_t remote_hold; // held in the measurement domain
   temp_deg_t local_hold; // held in the measurement domain
   logic meas_toggle; // flips per finished conversion

   meas_capture u_capture
   (
      .i_meas_clk(i_meas_clk),
      .i_rst(i_rst),
      .i_sample_stb(i_sample_stb),
      .i_remote_temp(i_remote_temp),
      .i_local_temp(i_local_temp),
      .o_remote_hold(remote_hold),
      .o_local_hold(local_hold),
      .o_toggle(meas_toggle)
   );

   logic tgl_s1_ff; // first stage, read only by the second
   logic tgl_s2_ff; // synchronised toggle
   logic tgl_s3_ff; // delayed copy for edge detect
   logic new_sample; // one cycle per crossed result

   // toggle synchroniser
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         tgl_s1_ff <= 1'b0;
         tgl_s2_ff <= 1'b0;
         tgl_s3_ff <= 1'b0;
      end
      else
      begin
         tgl_s1_ff <= meas_toggle;
         tgl_s2_ff <= tgl_s1_ff;
         tgl_s3_ff <= tgl_s2_ff;
      end
   end

   assign new_sample = tgl_s2_ff ^ tgl_s3_ff;

   temp_deg_t remote_temp_ff; // latest remote reading
   temp_deg_t local_temp_ff; // latest local reading
   logic temp_valid_ff; // a reading has arrived

   // held words are stable once the toggle edge is seen
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         remote_temp_ff <= 8'h00;
         local_temp_ff <= 8'h00;
         temp_valid_ff <= 1'b0;
      end
      else if (new_sample)
      begin
         remote_temp_ff <= remote_hold;
         local_temp_ff <= local_hold;
         temp_valid_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // level synchronisers
   // ----------------------------------------------------------------
   logic [3:0] lvl_in; // busy, fault, detect, beta enable
   logic [3:0] lvl_s1_ff; // first stage
   logic [3:0] lvl_s2_ff; // usable levels

   assign lvl_in = {i_busy, i_diode_fault,
                    i_beta_comp_transistor_detect, i_beta_comp_enable};

   // two flops per level, one per bit
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_lvl
         always_ff @(posedge i_clk or posedge i_rst)
         begin
            if (i_rst)
            begin
               lvl_s1_ff[gi] <= 1'b0;
               lvl_s2_ff[gi] <= 1'b0;
            end
            else
            begin
               lvl_s1_ff[gi] <= lvl_in[gi];
               lvl_s2_ff[gi] <= lvl_s1_ff[gi];
            end
         end
      end
   endgenerate

   logic busy_sync; // conversion running
   logic fault_sync; // diode missing or faulty
   logic detect_sync; // discrete transistor present
   logic beta_en_sync; // beta compensation on

   assign busy_sync = lvl_s2_ff[3];
   assign fault_sync = lvl_s2_ff[2];
   assign detect_sync = lvl_s2_ff[1];
   assign beta_en_sync = lvl_s2_ff[0];

   // ----------------------------------------------------------------
   // power-up sequence
   // ----------------------------------------------------------------
   pwr_state_t pwr_state_ff; // waiting or ready
   logic [31:0] pwr_cnt_ff; // cycles since reset release

   // count out the power-up time, then stay ready
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pwr_state_ff <= PWR_WAIT;
         pwr_cnt_ff <= 32'h0000_0000;
      end
      else
      begin
         unique case (pwr_state_ff)
            PWR_WAIT:
            begin
               if (pwr_cnt_ff >= POWERUP_CYCLES - 1)
                  pwr_state_ff <= PWR_READY;
               else
                  pwr_cnt_ff <= pwr_cnt_ff + 32'h0000_0001;
            end
            PWR_READY:
            begin
               pwr_state_ff <= PWR_READY;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // writable limits
   // ----------------------------------------------------------------
   temp_deg_t remote_ot_limit_ff; // remote over-temperature limit
   temp_deg_t remote_crit_limit_ff; // remote critical limit
   temp_deg_t local_limit_ff; // shared local limit
   logic [4:0] hyst_ff; // common hysteresis

   // host writes; offsets without storage fall through untouched
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         remote_ot_limit_ff <= `RST_REMOTE_OT_LIMIT;
         remote_crit_limit_ff <= `RST_REMOTE_CRIT_LIMIT;
         local_limit_ff <= `RST_LOCAL_LIMIT;
         hyst_ff <= `RST_COMMON_HYST;
      end
      else if (i_wr_en)
      begin
         unique case (i_addr)
            // either alias reaches the same storage
            `OFS_REMOTE_OT_LIMIT, `OFS_REMOTE_OT_ALIAS:
               remote_ot_limit_ff <= i_wr_data;
            `OFS_REMOTE_CRIT_LIMIT:
               remote_crit_limit_ff <= i_wr_data;
            `OFS_LOCAL_LIMIT:
               local_limit_ff <= i_wr_data;
            `OFS_COMMON_HYST:
               hyst_ff <= i_wr_data[`HYST_MSB:0];
            // status and id offsets take no write
            default:
               hyst_ff <= hyst_ff;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // limit comparators with hysteresis
   // ----------------------------------------------------------------
   // temp + hyst < limit avoids underflow of limit - hyst
   function automatic logic next_flag(input logic cur,
                                      input temp_deg_t temp,
                                      input temp_deg_t limit,
                                      input logic [4:0] hyst);
      logic [8:0] raised;
      raised = {1'b0, temp} + {4'h0, hyst};
      if (temp > limit)
         next_flag = 1'b1;
      else if (raised < {1'b0, limit})
         next_flag = 1'b0;
      else
         next_flag = cur;
   endfunction

   logic remote_overtemp_flag_ff; // remote over limit
   logic remote_critical_flag_ff; // remote over critical
   logic local_limit_flag_ff; // local over shared limit

   // flags are re-evaluated every cycle once a first reading has arrived, so limit and hysteresis writes also move them
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         remote_overtemp_flag_ff <= 1'b0;
         remote_critical_flag_ff <= 1'b0;
         local_limit_flag_ff <= 1'b0;
      end
      else if (temp_valid_ff)
      begin
         remote_overtemp_flag_ff <= next_flag(remote_overtemp_flag_ff,
            remote_temp_ff, remote_ot_limit_ff, hyst_ff);
         remote_critical_flag_ff <= next_flag(remote_critical_flag_ff,
            remote_temp_ff, remote_crit_limit_ff, hyst_ff);
         local_limit_flag_ff <= next_flag(local_limit_flag_ff,
            local_temp_ff, local_limit_ff, hyst_ff);
      end
   end

   // alarm pins from the flags
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_critical_alarm_output <= 1'b0;
         o_overtemp_shutdown_output <= 1'b0;
      end
      else
      begin
         o_critical_alarm_output <= remote_critical_flag_ff |
                                    local_limit_flag_ff;
         o_overtemp_shutdown_output <= remote_overtemp_flag_ff |
                                       local_limit_flag_ff;
      end
   end

   // ----------------------------------------------------------------
   // status words
   // ----------------------------------------------------------------
   logic [7:0] primary_status; // first status word
   logic [7:0] secondary_status; // second status word

   // assemble the first status word; gaps are zero
   always_comb
   begin
      primary_status = 8'h00;
      primary_status[`PST_BUSY_BIT] = busy_sync;
      primary_status[`PST_REMOTE_OT_BIT] = remote_overtemp_flag_ff;
      primary_status[`PST_DIODE_FAULT_BIT] = fault_sync;
      primary_status[`PST_REMOTE_CRIT_BIT] = remote_critical_flag_ff;
      primary_status[`PST_LOCAL_BIT] = local_limit_flag_ff;
   end

   // assemble the second status word; low six bits zero
   always_comb
   begin
      secondary_status = 8'h00;
      secondary_status[`SST_NOT_READY_BIT] =
         (pwr_state_ff == PWR_WAIT);
      secondary_status[`SST_DETECT_BIT] =
         detect_sync & beta_en_sync;
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [7:0] nxt_rd_data; // word selected by address

   // address decode; unmapped offsets read zero
   always_comb
   begin
      unique case (i_addr)
         `OFS_PRIMARY_STATUS: nxt_rd_data = primary_status;
         `OFS_REMOTE_OT_LIMIT, `OFS_REMOTE_OT_ALIAS:
            nxt_rd_data = remote_ot_limit_ff;
         `OFS_REMOTE_CRIT_LIMIT: nxt_rd_data = remote_crit_limit_ff;
         `OFS_LOCAL_LIMIT: nxt_rd_data = local_limit_ff;
         `OFS_COMMON_HYST: nxt_rd_data = {3'h0, hyst_ff};
         `OFS_SECONDARY_STATUS: nxt_rd_data = secondary_status;
         `OFS_MAKER_ID: nxt_rd_data = MAKER_ID;
         `OFS_SILICON_REV: nxt_rd_data = SILICON_REV;
         default: nxt_rd_data = 8'h00;
      endcase
   end

   // registered read answer, one cycle after the strobe
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rd_data <= 8'h00;
         o_rd_valid <= 1'b0;
      end
      else
      begin
         o_rd_valid <= i_rd_en;
         if (i_rd_en)
            o_rd_data <= nxt_rd_data;
      end
   end
endmodule

// File: tb/temp_status_bank_asserts.sv
// concurrent checks on the register port of the status and limit bank
// assumes binding to temp_status_bank, all checks on i_clk
`timescale 1ns/1ps
module temp_status_bank_asserts
   import temp_status_pkg::*;
#(
   parameter int unsigned POWERUP_CYCLES = 20,
   parameter logic [7:0] MAKER_ID = 8'h5A,
   parameter logic [7:0] SILICON_REV = 8'h03
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_data,
   input wire logic i_rd_en,
   input wire logic [7:0] o_rd_data,
   input wire logic o_rd_valid,
   // status levels
   input wire logic i_busy,
   input wire logic i_diode_fault
);
   // ------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   int unsigned edges_ff; // edges since release, saturating
   int unsigned nxt_edges;
   assign nxt_edges = (edges_ff < POWERUP_CYCLES + 8) ? edges_ff + 1
                                                      : edges_ff;
   // count edges after reset release
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         edges_ff <= 0;
      else
         edges_ff <= nxt_edges;
   end
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_VALID_AFTER_READ: assert property (i_rd_en |=> o_rd_valid)
      else $error("read answer missing");
   AST_VALID_ONLY_READ: assert property (!i_rd_en |=> !o_rd_valid)
      else $error("read answer without request");
   AST_PST_ZERO: assert property
      (i_rd_en && i_addr == 8'h02 |=> (o_rd_data & 8'h68) == 8'h00)
      else $error("unused primary status bits set");
   AST_SST_ZERO: assert property
      (i_rd_en && i_addr == 8'h33 |=> o_rd_data[5:0] == 6'h00)
      else $error("unused secondary status bits set");
   AST_HYST_UPPER: assert property
      (i_rd_en && i_addr == 8'h21 |=> o_rd_data[7:5] == 3'h0)
      else $error("hysteresis upper bits set");
   AST_MAKER: assert property
      (i_rd_en && i_addr == 8'hFE |=> o_rd_data == MAKER_ID)
      else $error("maker code wrong");
   AST_REVISION: assert property
      (i_rd_en && i_addr == 8'hFF |=> o_rd_data == SILICON_REV)
      else $error("revision code wrong");
   AST_BUSY: assert property
      ($stable(i_busy) [*4] ##0 (i_rd_en && i_addr == 8'h02)
       |=> o_rd_data[7] == $past(i_busy))
      else $error("busy bit does not follow conversion");
   AST_FAULT: assert property
      ($stable(i_diode_fault) [*4] ##0 (i_rd_en && i_addr == 8'h02)
       |=> o_rd_data[2] == $past(i_diode_fault))
      else $error("diode fault bit wrong");
   AST_ALIAS: assert property
      ((i_wr_en && i_addr == 8'h0D) ##2 (i_rd_en && i_addr == 8'h07)
       |=> o_rd_data == $past(i_wr_data, 3))
      else $error("aliased limit write not seen");
   AST_NOT_READY: assert property
      (i_rd_en && i_addr == 8'h33 && edges_ff + 3 < POWERUP_CYCLES
       |=> o_rd_data[7])
      else $error("ready too early");
   AST_READY: assert property
      (i_rd_en && i_addr == 8'h33 && edges_ff > POWERUP_CYCLES + 3
       |=> !o_rd_data[7])
      else $error("not ready too long");
endmodule

bind temp_status_bank temp_status_bank_asserts #(
   .POWERUP_CYCLES(POWERUP_CYCLES), .MAKER_ID(MAKER_ID),
   .SILICON_REV(SILICON_REV)
) u_asserts (
   .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_en(i_wr_en),
   .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
   .o_rd_valid(o_rd_valid), .i_busy(i_busy), .i_diode_fault(i_diode_fault)
);

// File: tb/reg_host_model.sv
// host standing in front of the byte-wide register port
// assumes tasks are entered at a falling edge of i_clk
`timescale 1ns/1ps
module reg_host_model (
   // clock and read answer
   input wire logic i_clk,
   input wire logic [7:0] i_rd_data,
   input wire logic i_rd_valid,
   // register requests
   output logic [7:0] o_addr,
   output logic o_wr_en,
   output logic [7:0] o_wr_data,
   output logic o_rd_en
);
   // idle request lines
   initial
   begin
      o_addr = 8'h00;
      o_wr_en = 1'b0;
      o_wr_data = 8'h00;
      o_rd_en = 1'b0;
   end
   // one write strobe of one cycle, then one idle cycle so that a
   // following call never raises a strobe in the step it was lowered
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      o_addr = a;
      o_wr_data = d;
      o_wr_en = 1'b1;
      @(negedge i_clk);
      o_wr_en = 1'b0;
      @(negedge i_clk);
   endtask
   // one read strobe, bounded wait for the answer
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic ok);
      o_addr = a;
      o_rd_en = 1'b1;
      @(negedge i_clk);
      o_rd_en = 1'b0;
      ok = 1'b0;
      d = 8'h00;
      for (int n = 0; n < 4 && !ok; n++)
      begin
         if (i_rd_valid === 1'b1)
         begin
            d = i_rd_data;
            ok = 1'b1;
         end
         else
            @(negedge i_clk);
      end
      // idle cycle before the next request
      @(negedge i_clk);
   endtask
endmodule

// File: tb/temp_status_bank_tb.sv
// self-checking bench for the sensor status and limit bank
// assumes the bank, its package and the host model are compiled first
`timescale 1ns/1ps
module temp_status_bank_tb;
   import temp_status_pkg::*;
   localparam int unsigned PWR = 20; // short power-up wait
   localparam logic [7:0] MAKER = 8'hA7; // value arbitrary
   localparam logic [7:0] REV = 8'h2C; // value arbitrary
   localparam logic [7:0] RA [9] = '{8'h07, 8'h0D, 8'h19, 8'h20, 8'h21,
                                     8'hFE, 8'hFF, 8'h02, 8'h40};
   localparam logic [7:0] RV [9] = '{8'h55, 8'h55, 8'h6E, 8'h55, 8'h0A,
                                     MAKER, REV, 8'h00, 8'h00};
   localparam logic [7:0] TR [6] = '{8'h50, 8'h51, 8'h4C, 8'h4A, 8'h61, 8'h00};
   localparam logic [7:0] TL [6] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h31};
   localparam logic [7:0] TS [6] = '{8'h00, 8'h10, 8'h10, 8'h00, 8'h12, 8'h01};
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_meas_clk = 1'b0;
   logic [7:0] i_addr, i_wr_data, o_rd_data;
   logic i_wr_en, i_rd_en, o_rd_valid, o_crit, o_ot;
   logic i_sample_stb = 1'b0;
   temp_deg_t i_remote_temp = 8'h00;
   temp_deg_t i_local_temp = 8'h00;
   logic i_busy = 1'b0;
   logic i_diode_fault = 1'b0;
   logic i_det = 1'b0;
   logic i_beta_en = 1'b0;
   int miscompares = 0;
   int tests_run = 0;
   // clocks, unrelated in phase
   always #4 i_clk = ~i_clk;
   initial
   begin
      #3;
      forever #62.5 i_meas_clk = ~i_meas_clk;
   end
   // ------------------------------------------------------------
   // design and host
   // ------------------------------------------------------------
   temp_status_bank #(.POWERUP_CYCLES(PWR), .MAKER_ID(MAKER),
                      .SILICON_REV(REV)) uut (
      .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_en(i_wr_en),
      .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
      .o_rd_valid(o_rd_valid), .i_meas_clk(i_meas_clk),
      .i_sample_stb(i_sample_stb), .i_remote_temp(i_remote_temp),
      .i_local_temp(i_local_temp), .i_busy(i_busy),
      .i_diode_fault(i_diode_fault), .i_beta_comp_transistor_detect(i_det),
      .i_beta_comp_enable(i_beta_en), .o_critical_alarm_output(o_crit),
      .o_overtemp_shutdown_output(o_ot));
   reg_host_model host (.i_clk(i_clk), .i_rd_data(o_rd_data),
      .i_rd_valid(o_rd_valid), .o_addr(i_addr), .o_wr_en(i_wr_en),
      .o_wr_data(i_wr_data), .o_rd_en(i_rd_en));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // compare and count
   task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   // read one register and compare
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      host.rd(a, d, ok);
      if (ok !== 1'b1)
      begin
         $display("wrong value read answer %h expected 1 seen 0", a);
         miscompares++;
         complete_run();
      end
      else
         ck($sformatf("register %h", a), e, d);
   endtask
   // reset across both clocks, ends at a falling edge
   task automatic do_reset();
      i_rst = 1'b1;
      repeat (8) @(negedge i_clk);
      @(posedge i_meas_clk);
      @(negedge i_clk);
      i_rst = 1'b0;
   endtask
   // one conversion result, then time to cross
   task automatic sample(input logic [7:0] r, input logic [7:0] l);
      @(negedge i_meas_clk);
      i_remote_temp = r;
      i_local_temp = l;
      i_sample_stb = 1'b1;
      @(negedge i_meas_clk);
      i_sample_stb = 1'b0;
      repeat (2) @(negedge i_meas_clk);
      @(negedge i_clk);
   endtask
   // hang guard
   initial
   begin
      repeat (20000) @(posedge i_clk);
      miscompares++;
      complete_run();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      do_reset();
      rc(8'h33, 8'h80);
      for (int i = 0; i < 9; i++)
         rc(RA[i], RV[i]);
      // writes to read-only and unmapped places
      for (int i = 5; i < 9; i++)
      begin
         host.wr(RA[i], 8'hFF);
         rc(RA[i], RV[i]);
      end
      host.wr(8'h33, 8'hFF);
      repeat (PWR) @(negedge i_clk);
      rc(8'h33, 8'h00);
      // transistor detect against compensation enable
      for (int i = 0; i < 4; i++)
      begin
         {i_det, i_beta_en} = 2'(i);
         repeat (4) @(negedge i_clk);
         rc(8'h33, (i == 3) ? 8'h40 : 8'h00);
      end
      i_busy = 1'b1;
      i_diode_fault = 1'b1;
      repeat (6) @(negedge i_clk);
      rc(8'h02, 8'h84);
      i_busy = 1'b0;
      i_diode_fault = 1'b0;
      repeat (6) @(negedge i_clk);
      rc(8'h02, 8'h00);
      host.wr(8'h0D, 8'h40);
      rc(8'h07, 8'h40);
      host.wr(8'h07, 8'hFF);
      rc(8'h0D, 8'hFF);
      host.wr(8'h21, 8'hFF);
      rc(8'h21, 8'h1F);
      // limits and hysteresis for the flag walk
      host.wr(8'h07, 8'h50);
      host.wr(8'h19, 8'h60);
      host.wr(8'h20, 8'h30);
      host.wr(8'h21, 8'h05);
      for (int i = 0; i < 6; i++)
      begin
         sample(TR[i], TL[i]);
         rc(8'h02, TS[i]);
         ck("alarms", {6'h00, TS[i][1] | TS[i][0], TS[i][4] | TS[i][0]},
            {6'h00, o_crit, o_ot});
      end
      host.wr(8'h07, 8'h12);
      do_reset();
      rc(8'h07, 8'h55);
      rc(8'h33, 8'hC0);
      complete_run();
   end
endmodule
